//--- design/uief_map.svh
`ifndef UIEF_MAP_SVH
`define UIEF_MAP_SVH

// Register byte offsets.
`define UIEF_OFS_EVT_FLAGS 12'h000
`define UIEF_OFS_EVT_EN 12'h004
`define UIEF_OFS_ERR_FLAGS 12'h008
`define UIEF_OFS_ERR_EN 12'h00c
`define UIEF_OFS_CTRL 12'h010
`define UIEF_OFS_TOK_STAT 12'h014

// Field positions.
`define UIEF_EVT_STALL 3'd7
`define UIEF_EVT_ATTACH 3'd6
`define UIEF_EVT_RESUME 3'd5
`define UIEF_EVT_IDLE 3'd4
`define UIEF_EVT_TOKEN 3'd3
`define UIEF_EVT_SOF 3'd2
`define UIEF_EVT_SUMMARY 3'd1
`define UIEF_EVT_RST_DET 3'd0
`define UIEF_ERR_BITSTUFF 3'd7
`define UIEF_ERR_BUS_MATRIX 3'd6
`define UIEF_ERR_DMA 3'd5
`define UIEF_ERR_TURNAROUND 3'd4
`define UIEF_ERR_PARTIAL 3'd3
`define UIEF_ERR_DATA_CRC 3'd2
`define UIEF_ERR_CRC5_EOF 3'd1
`define UIEF_ERR_PID 3'd0
`define UIEF_CTRL_HOST 0

// Reset values.
`define UIEF_RST_BYTE 8'h00
`define UIEF_RST_WORD 32'h0000_0000

// Timing.
`define UIEF_CLK_PERIOD_NS 50
`define UIEF_ATTACH_IDLE_NS 2500
`define UIEF_BIT_TIME_PS 83333
`define UIEF_TURNAROUND_BITS 16

`endif

//--- design/uief_pkg.sv
package uief_pkg;

	// Hardware event pulses from the protocol engine.
	typedef struct packed {
		logic stall;
		logic attach;
		logic resume;
		logic idle;
		logic sof;
		logic bus_reset;
		logic detach;
	} uief_evt_t;

	// Error pulses from the protocol engine and DMA.
	typedef struct packed {
		logic bitstuff;
		logic bus_matrix;
		logic dma;
		logic partial_byte;
		logic data_crc;
		logic token_crc;
		logic pid;
	} uief_err_t;

	// Transaction status entry pushed on token completion.
	typedef struct packed {
		logic [3:0] endpoint;
		logic dir_tx;
		logic odd_bank;
	} uief_tok_t;

	typedef enum logic [1:0] {
		UIEF_TA_IDLE = 2'b00,
		UIEF_TA_WAIT = 2'b01
	} uief_ta_state_t;

endpackage

//--- design/uief_top.sv
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/10ps
`include "uief_map.svh"

// Contract
// - Device mode: bit 0 flags a valid bus reset.
// - Host mode: bit 0 flags a detached peripheral.
// - Attach counts only with host on, bus idle 2.5 us, no SE0.
// - Clearing the token flag advances the transaction status FIFO.
// - Summary error flag set only by enabled error flags.
// - Eight enable bits gate the eight event flags by position.
// - Errors reach the module interrupt only with summary enable set.
// - Bit-stuff violation rejects packet, sets bit 7.
// - Bad table or buffer address sets bit 6.
// - DMA late grant or truncation sets bit 5.
// - Idle over 16 bit times after EOP sets bit 4.
// - Data field not whole bytes sets bit 3.
// - Data CRC16 failure rejects packet, sets bit 2.
// - Device mode: token CRC5 failure sets bit 1.
// - Host mode: busy when frame counter hits zero sets bit 1.
// - PID check failure sets bit 0.
// - Error flags hardware set, reset zero, write one clears.
// - Error enables match error flag positions, bit 1 dual use.
// - Bits 31 to 8 read zero; enables read, write, reset zero.
// - Host capability bit selects host or device meaning.
// - Token flag means status entry of that token is readable.
module uief_top
	import uief_pkg::*;
#(
	parameter int TOK_DEPTH = 4,
	parameter int TOK_AW = 2
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic nrst,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Protocol engine events.
	input wire uief_evt_t evt_in,
	input wire uief_err_t err_in,
	input wire logic token_done,
	input wire uief_tok_t token_stat,
	input wire logic eop_done,
	input wire logic reply_expected,
	input wire logic reply_start,
	input wire logic frame_count_zero,
	input wire logic link_busy,
	// Bus line pins.
	input wire logic line_se0_pin,
	input wire logic line_active_pin,
	// Block outputs.
	output logic host_capability_enable,
	output logic packet_reject,
	output logic module_interrupt
);

	// ----------------------------------------------------------------
	// Timing constants
	// ----------------------------------------------------------------

	localparam int ATTACH_CYC =
		(`UIEF_ATTACH_IDLE_NS + `UIEF_CLK_PERIOD_NS - 1) /
		`UIEF_CLK_PERIOD_NS;
	localparam int TURN_CYC =
		(`UIEF_TURNAROUND_BITS * `UIEF_BIT_TIME_PS +
		`UIEF_CLK_PERIOD_NS * 1000 - 1) /
		(`UIEF_CLK_PERIOD_NS * 1000);
	localparam logic [7:0] ATTACH_LIM = 8'(ATTACH_CYC);
	localparam logic [7:0] TURN_LIM = 8'(TURN_CYC);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------

	logic se0_s1_ff;
	logic se0_s2_ff;
	logic act_s1_ff;
	logic act_s2_ff;
	logic host_en_ff;
	logic host_prev_ff;
	logic [7:0] idle_cnt_ff;
	logic bus_quiet;
	logic [7:0] evt_flags_ff;
	logic [7:0] nxt_evt_flags;
	logic [7:0] evt_en_ff;
	logic [7:0] err_flags_ff;
	logic [7:0] nxt_err_flags;
	logic [7:0] err_en_ff;
	logic [7:0] evt_set;
	logic [7:0] err_set;
	logic [7:0] evt_view;
	uief_ta_state_t ta_state_ff;
	uief_ta_state_t nxt_ta_state;
	logic [7:0] ta_cnt_ff;
	logic ta_timeout;
	uief_tok_t tok_mem_ff [TOK_DEPTH];
	logic [TOK_AW-1:0] tok_rd_ff;
	logic [TOK_AW-1:0] tok_wr_ff;
	logic [TOK_AW:0] tok_cnt_ff;
	logic tok_empty;
	logic tok_full;
	logic tok_push;
	logic tok_pop;
	logic [31:0] rdata_ff;
	logic hit_ff;
	logic wr_fire;
	logic [7:0] wbyte;
	logic reject_ff;
	logic irq_ff;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------

	function automatic logic reg_hit(input logic [11:0] a);
		reg_hit = (a == `UIEF_OFS_EVT_FLAGS) ||
			(a == `UIEF_OFS_EVT_EN) ||
			(a == `UIEF_OFS_ERR_FLAGS) ||
			(a == `UIEF_OFS_ERR_EN) ||
			(a == `UIEF_OFS_CTRL) ||
			(a == `UIEF_OFS_TOK_STAT);
	endfunction

	function automatic logic w1c_to(input logic [11:0] a,
		input logic [11:0] ofs);
		w1c_to = (a == ofs);
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			se0_s1_ff <= 1'b0;
			se0_s2_ff <= 1'b0;
			act_s1_ff <= 1'b0;
			act_s2_ff <= 1'b0;
		end else begin
			se0_s1_ff <= line_se0_pin;
			se0_s2_ff <= se0_s1_ff;
			act_s1_ff <= line_active_pin;
			act_s2_ff <= act_s1_ff;
		end
	end

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------

	assign wr_fire = psel && penable && pwrite;
	assign wbyte = pwdata[7:0];

	// Read data and decode are captured in the setup cycle.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rdata_ff <= `UIEF_RST_WORD;
			hit_ff <= 1'b0;
		end else if (psel && !penable) begin
			hit_ff <= reg_hit(paddr);
			rdata_ff <= `UIEF_RST_WORD;
			unique case (paddr)
				`UIEF_OFS_EVT_FLAGS: rdata_ff[7:0] <= evt_view;
				`UIEF_OFS_EVT_EN: rdata_ff[7:0] <= evt_en_ff;
				`UIEF_OFS_ERR_FLAGS: rdata_ff[7:0] <= err_flags_ff;
				`UIEF_OFS_ERR_EN: rdata_ff[7:0] <= err_en_ff;
				`UIEF_OFS_CTRL: rdata_ff[`UIEF_CTRL_HOST] <= host_en_ff;
				`UIEF_OFS_TOK_STAT: begin
					if (!tok_empty) begin
						rdata_ff[7:2] <= tok_mem_ff[tok_rd_ff];
					end
				end
				default: rdata_ff <= `UIEF_RST_WORD;
			endcase
		end
	end

	assign pready = psel && penable;
	assign pslverr = psel && penable && !hit_ff;
	assign prdata = rdata_ff;

	// ----------------------------------------------------------------
	// Control and enable registers
	// ----------------------------------------------------------------

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			evt_en_ff <= `UIEF_RST_BYTE;
			err_en_ff <= `UIEF_RST_BYTE;
			host_en_ff <= 1'b0;
		end else if (wr_fire) begin
			if (w1c_to(paddr, `UIEF_OFS_EVT_EN)) begin
				evt_en_ff <= wbyte;
			end
			if (w1c_to(paddr, `UIEF_OFS_ERR_EN)) begin
				err_en_ff <= wbyte;
			end
			if (w1c_to(paddr, `UIEF_OFS_CTRL)) begin
				host_en_ff <= wbyte[`UIEF_CTRL_HOST];
			end
		end
	end

	assign host_capability_enable = host_en_ff;

	// ----------------------------------------------------------------
	// Attach qualification
	// ----------------------------------------------------------------

	// The attach idle counter restarts whenever the host bit changes.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			host_prev_ff <= 1'b0;
			idle_cnt_ff <= 8'h00;
		end else begin
			host_prev_ff <= host_en_ff;
			if (act_s2_ff || (host_prev_ff != host_en_ff)) begin
				idle_cnt_ff <= 8'h00;
			end else if (idle_cnt_ff != ATTACH_LIM) begin
				idle_cnt_ff <= idle_cnt_ff + 8'h01;
			end
		end
	end

	assign bus_quiet = (idle_cnt_ff == ATTACH_LIM);

	// ----------------------------------------------------------------
	// Turnaround timer
	// ----------------------------------------------------------------

	always_comb begin
		nxt_ta_state = ta_state_ff;
		unique case (ta_state_ff)
			UIEF_TA_IDLE: begin
				if (eop_done && reply_expected) begin
					nxt_ta_state = UIEF_TA_WAIT;
				end
			end
			UIEF_TA_WAIT: begin
				if (reply_start || ta_timeout || eop_done) begin
					nxt_ta_state = UIEF_TA_IDLE;
				end
			end
			default: nxt_ta_state = UIEF_TA_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ta_state_ff <= UIEF_TA_IDLE;
			ta_cnt_ff <= 8'h00;
		end else begin
			ta_state_ff <= nxt_ta_state;
			if (ta_state_ff == UIEF_TA_WAIT) begin
				ta_cnt_ff <= ta_cnt_ff + 8'h01;
			end else begin
				ta_cnt_ff <= 8'h00;
			end
		end
	end

	assign ta_timeout = (ta_state_ff == UIEF_TA_WAIT) &&
		(ta_cnt_ff == TURN_LIM) && !reply_start;

	// ----------------------------------------------------------------
	// Transaction status FIFO
	// ----------------------------------------------------------------

	assign tok_empty = (tok_cnt_ff == '0);
	assign tok_full = (tok_cnt_ff == (TOK_AW+1)'(TOK_DEPTH));
	assign tok_push = token_done && !tok_full;
	assign tok_pop = wr_fire && w1c_to(paddr, `UIEF_OFS_EVT_FLAGS) &&
		wbyte[`UIEF_EVT_TOKEN] && !tok_empty;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			tok_rd_ff <= '0;
			tok_wr_ff <= '0;
			tok_cnt_ff <= '0;
		end else begin
			if (tok_push) begin
				tok_wr_ff <= tok_wr_ff + 1'b1;
			end
			if (tok_pop) begin
				tok_rd_ff <= tok_rd_ff + 1'b1;
			end
			if (tok_push && !tok_pop) begin
				tok_cnt_ff <= tok_cnt_ff + 1'b1;
			end else if (tok_pop && !tok_push) begin
				tok_cnt_ff <= tok_cnt_ff - 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (tok_push) begin
			tok_mem_ff[tok_wr_ff] <= token_stat;
		end
	end

	// ----------------------------------------------------------------
	// Flag sources
	// ----------------------------------------------------------------

	always_comb begin
		evt_set = 8'h00;
		evt_set[`UIEF_EVT_STALL] = evt_in.stall;
		evt_set[`UIEF_EVT_ATTACH] = evt_in.attach && host_en_ff &&
			bus_quiet && !se0_s2_ff;
		evt_set[`UIEF_EVT_RESUME] = evt_in.resume;
		evt_set[`UIEF_EVT_IDLE] = evt_in.idle;
		evt_set[`UIEF_EVT_SOF] = evt_in.sof;
		evt_set[`UIEF_EVT_RST_DET] = host_en_ff ?
			evt_in.detach :
			evt_in.bus_reset;
	end

	always_comb begin
		err_set = 8'h00;
		err_set[`UIEF_ERR_BITSTUFF] = err_in.bitstuff;
		err_set[`UIEF_ERR_BUS_MATRIX] = err_in.bus_matrix;
		err_set[`UIEF_ERR_DMA] = err_in.dma;
		err_set[`UIEF_ERR_TURNAROUND] = ta_timeout;
		err_set[`UIEF_ERR_PARTIAL] = err_in.partial_byte;
		err_set[`UIEF_ERR_DATA_CRC] = err_in.data_crc;
		err_set[`UIEF_ERR_CRC5_EOF] = host_en_ff ?
			(frame_count_zero && link_busy) :
			err_in.token_crc;
		err_set[`UIEF_ERR_PID] = err_in.pid;
	end

	// ----------------------------------------------------------------
	// Sticky flags
	// ----------------------------------------------------------------

	// A set in the cycle of a clear wins.
	for (genvar i = 0; i < 8; i++) begin : g_flags
		logic evt_clr;
		logic err_clr;
		assign evt_clr = wr_fire && wbyte[i] &&
			w1c_to(paddr, `UIEF_OFS_EVT_FLAGS);
		assign err_clr = wr_fire && wbyte[i] &&
			w1c_to(paddr, `UIEF_OFS_ERR_FLAGS);
		assign nxt_evt_flags[i] = (evt_flags_ff[i] && !evt_clr) ||
			evt_set[i];
		assign nxt_err_flags[i] = (err_flags_ff[i] && !err_clr) ||
			err_set[i];
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			evt_flags_ff <= `UIEF_RST_BYTE;
		end else begin
			evt_flags_ff <= nxt_evt_flags;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			err_flags_ff <= `UIEF_RST_BYTE;
		end else begin
			err_flags_ff <= nxt_err_flags;
		end
	end

	// Token and summary bits are live views, not stored flags.
	always_comb begin
		evt_view = evt_flags_ff;
		evt_view[`UIEF_EVT_TOKEN] = !tok_empty;
		evt_view[`UIEF_EVT_SUMMARY] =
			|(err_flags_ff & err_en_ff);
	end

	// ----------------------------------------------------------------
	// Packet reject and module interrupt
	// ----------------------------------------------------------------

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			reject_ff <= 1'b0;
		end else begin
			reject_ff <= err_in.bitstuff ||
				err_in.data_crc ||
				(!host_en_ff && err_in.token_crc);
		end
	end

	assign packet_reject = reject_ff;

	// Summary bit passes only through its own enable.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(evt_view & evt_en_ff);
		end
	end

	assign module_interrupt = irq_ff;

endmodule

//--- verification/uief_assertions.sv
`timescale 1ns/10ps
module uief_chk
	import uief_pkg::*;
(
	// Clock and reset.
	input wire logic core_clk,
	input wire logic nrst,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	// Engine and outputs.
	input wire uief_err_t err_in,
	input wire logic host_capability_enable,
	input wire logic packet_reject,
	input wire logic module_interrupt
);
	// ------
	// Properties.
	// ------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	sequence s_acc;
		psel && penable;
	endsequence
	sequence s_wr;
		psel && penable && pwrite;
	endsequence
	AST_REJ_BITSTUFF: assert property (err_in.bitstuff |=> packet_reject)
		else $error("bit-stuff error did not reject");
	AST_REJ_CRC16: assert property (err_in.data_crc |=> packet_reject)
		else $error("data crc error did not reject");
	AST_REJ_CRC5: assert property (err_in.token_crc && !host_capability_enable |=> packet_reject)
		else $error("token crc error did not reject");
	AST_REJ_CAUSE: assert property (packet_reject |-> $past(err_in.bitstuff || err_in.data_crc
		|| (err_in.token_crc && !host_capability_enable)))
		else $error("reject without cause");
	AST_UPPER_ZERO: assert property (s_acc ##0 !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	AST_UNMAPPED: assert property (s_acc ##0 (paddr > 12'h014 || paddr[1:0] != 2'b00) |-> pslverr)
		else $error("unmapped access not refused");
	AST_HOST_WR: assert property (s_wr ##0 paddr == 12'h010 |=>
		host_capability_enable == $past(pwdata[0]))
		else $error("host capability bit not written");
	AST_IRQ_FALL: assert property ($fell(module_interrupt) |-> $past(psel && penable && pwrite, 2))
		else $error("interrupt fell without a write");
endmodule

//--- verification/uief_usb_link.sv
`timescale 1ns/10ps
module uief_usb_link (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic nrst,
	// Bench control.
	input wire logic quiet,
	input wire logic [7:0] reply_delay,
	input wire logic eop_done,
	input wire logic reply_expected,
	input wire logic se0_req,
	// Bus side.
	output logic line_active_pin,
	output logic line_se0_pin,
	output logic reply_start
);
	logic [7:0] cnt_ff;
	// The bench asks for a single-ended zero to test attach qualification.
	assign line_se0_pin = se0_req;
	// The line toggles while traffic runs and rests when quiet.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) line_active_pin <= 1'b0;
		else line_active_pin <= quiet ? 1'b0 : ~line_active_pin;
	end
	// A delay of zero means the far side never answers.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cnt_ff <= 8'h00;
			reply_start <= 1'b0;
		end else begin
			reply_start <= (cnt_ff == 8'h01);
			if (eop_done && reply_expected) cnt_ff <= reply_delay;
			else if (cnt_ff != 8'h00) cnt_ff <= cnt_ff - 8'h01;
		end
	end
endmodule

//--- verification/tb.sv
`timescale 1ns/10ps
module tb;
	import uief_pkg::*;
	logic core_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rdat, seed = 32'h6588;
	logic pready, pslverr, slv, hce, prej, irq, act, se0, rstart, quiet = 1'b0;
	logic token_done = 1'b0, eop_done = 1'b0, rexp = 1'b0;
	logic fcz = 1'b0, lbusy = 1'b0, se0_req = 1'b0;
	logic [7:0] rdly = 8'h00;
	uief_evt_t evt_in = '0;
	uief_err_t err_in = '0;
	uief_tok_t token_stat = '0;
	uief_tok_t tokq[$];
	int errors = 0, checks_done = 0, een, exp_e;
	always #25 core_clk = ~core_clk;
	uief_top dut(.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .evt_in(evt_in), .err_in(err_in), .token_done(token_done),
		.token_stat(token_stat), .eop_done(eop_done), .reply_expected(rexp),
		.reply_start(rstart), .frame_count_zero(fcz), .link_busy(lbusy),
		.line_se0_pin(se0), .line_active_pin(act), .host_capability_enable(hce),
		.packet_reject(prej), .module_interrupt(irq));
	uief_usb_link u_link(.core_clk(core_clk), .nrst(nrst), .quiet(quiet), .reply_delay(rdly),
		.eop_done(eop_done), .reply_expected(rexp), .se0_req(se0_req), .line_active_pin(act),
		.line_se0_pin(se0), .reply_start(rstart));
	// ------
	// Tasks.
	// ------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task end_sim;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			errors++;
			end_sim();
		end
		rdat = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask
	task pulse_evt(input logic [6:0] v);
		evt_in <= uief_evt_t'(v);
		@(posedge core_clk);
		evt_in <= '0;
	endtask
	// ------
	// Main sequence.
	// ------
	initial begin
		repeat (5) @(posedge core_clk);
		nrst <= 1'b1;
		for (int a = 0; a < 6; a++) rd(12'(4 * a), 32'h0);
		for (int a = 1; a < 4; a += 2) begin
			seed = lfsr(seed);
			apb(1'b1, 12'(4 * a), seed);
			rd(12'(4 * a), {24'h0, seed[7:0]});
		end
		seed = lfsr(seed);
		een = (int'(seed[7:0]) & 'h7f) | 1;
		apb(1'b1, 12'h00c, een);
		apb(1'b1, 12'h004, 32'h03);
		for (int i = 0; i < 7; i++) begin
			err_in <= uief_err_t'(7'h01 << i);
			@(posedge core_clk);
			err_in <= '0;
			exp_e = (i < 4) ? (1 << i) : (2 << i);
			apb(1'b1, 12'h008, 32'h0);
			rd(12'h008, exp_e);
			rd(12'h000, ((exp_e & een) != 0) ? 2 : 0);
			chk({31'h0, irq}, ((exp_e & een) != 0) ? 1 : 0);
			apb(1'b1, 12'h008, exp_e);
			rd(12'h008, 32'h0);
		end
		// Without the summary enable an enabled error must stay off the interrupt.
		apb(1'b1, 12'h004, 32'h01);
		err_in <= uief_err_t'(7'h01);
		@(posedge core_clk);
		err_in <= '0;
		rd(12'h000, 32'h2);
		chk({31'h0, irq}, 0);
		apb(1'b1, 12'h008, 32'h1);
		apb(1'b1, 12'h004, 32'h03);
		rexp <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			eop_done <= 1'b1;
			@(posedge core_clk);
			eop_done <= 1'b0;
			repeat (35) @(posedge core_clk);
			rd(12'h008, k ? 32'h0 : 32'h10);
			apb(1'b1, 12'h008, 32'h10);
			rdly <= 8'd5;
		end
		pulse_evt(7'h02);
		rd(12'h000, 32'h1);
		chk({31'h0, irq}, 1);
		apb(1'b1, 12'h000, 32'h1);
		repeat (2) @(posedge core_clk);
		chk({31'h0, irq}, 0);
		apb(1'b1, 12'h010, 32'h1);
		@(posedge core_clk);
		chk({31'h0, hce}, 1);
		pulse_evt(7'h01);
		rd(12'h000, 32'h1);
		apb(1'b1, 12'h000, 32'h1);
		fcz <= 1'b1;
		lbusy <= 1'b1;
		@(posedge core_clk);
		fcz <= 1'b0;
		lbusy <= 1'b0;
		rd(12'h008, 32'h2);
		apb(1'b1, 12'h008, 32'h2);
		// In host mode a token CRC pulse or an idle frame end leaves bit 1 clear.
		fcz <= 1'b1;
		err_in <= uief_err_t'(7'h02);
		@(posedge core_clk);
		fcz <= 1'b0;
		err_in <= '0;
		rd(12'h008, 32'h0);
		pulse_evt(7'h20);
		rd(12'h000, 32'h0);
		quiet <= 1'b1;
		repeat (60) @(posedge core_clk);
		se0_req <= 1'b1;
		repeat (4) @(posedge core_clk);
		pulse_evt(7'h20);
		rd(12'h000, 32'h0);
		se0_req <= 1'b0;
		repeat (4) @(posedge core_clk);
		pulse_evt(7'h20);
		rd(12'h000, 32'h40);
		apb(1'b1, 12'h000, 32'h40);
		for (int i = 0; i < 2; i++) begin
			seed = lfsr(seed);
			token_stat <= uief_tok_t'(seed[5:0]);
			token_done <= 1'b1;
			tokq.push_back(uief_tok_t'(seed[5:0]));
			@(posedge core_clk);
		end
		token_done <= 1'b0;
		while (tokq.size() > 0) begin
			rd(12'h014, {24'h0, tokq[0], 2'b00});
			rd(12'h000, 32'h8);
			apb(1'b1, 12'h000, 32'h8);
			void'(tokq.pop_front());
		end
		rd(12'h000, 32'h0);
		apb(1'b0, 12'h020, 32'h0);
		chk({31'h0, slv}, 1);
		end_sim();
	end
endmodule
bind uief_top uief_chk u_chk(.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
	.err_in(err_in), .host_capability_enable(host_capability_enable),
	.packet_reject(packet_reject), .module_interrupt(module_interrupt));
